// file: core/dwscu_defs.vh
// Constants for the dual wiper serial command unit
`ifndef DWSCU_DEFS_VH
`define DWSCU_DEFS_VH
`define DWSCU_WORD_BITS 16
`define DWSCU_SET_BITS 8
`define DWSCU_TAPS 256
`define DWSCU_OP_LOAD_CH1 8'hB0
`define DWSCU_OP_LOAD_CH2 8'hB1
`define DWSCU_OP_INC_CH1 8'hE0
`define DWSCU_OP_SAVE_CH1 8'h20
`define DWSCU_OP_NOP 8'h00
`define DWSCU_OP_RESTORE1 8'h10
`define DWSCU_OP_RESTORE8 8'h80
`define DWSCU_SETTING_RST 8'h80
`define DWSCU_ECHO_RST 16'h0000
`define DWSCU_OP_BITS 8
`define DWSCU_CNT_BITS 5
`define DWSCU_CNT_ZERO 5'h00
`define DWSCU_CNT_ONE 5'h01
`define DWSCU_CNT_FULL 5'h10
`define DWSCU_CNT_MAX 5'h1f
`define DWSCU_ECHO_TOP 4'hf
`define DWSCU_SETTING_STEP 8'h01
`define DWSCU_SERIAL_OUT_RST 1'h0
`define DWSCU_SCLK_RST 1'h0
`endif

// file: core/dwscu_top.v
// Serial command unit for a dual 256-tap wiper pair
`timescale 1ns/1ps
`include "dwscu_defs.vh"
module dwscu_top #(
  parameter SET_BITS = `DWSCU_SET_BITS,
  parameter TAPS = `DWSCU_TAPS
) (
  input wire SYS_CLK_IN,
  input wire RST_N_IN,
  input wire CS_N_IN,
  input wire SCLK_IN,
  input wire SERIAL_IN_IN,
  output wire SERIAL_OUT_OUT,
  output wire [SET_BITS-1:0] WIPER_SETTING_CH1_OUT,
  output wire [SET_BITS-1:0] WIPER_SETTING_CH2_OUT,
  output wire [SET_BITS-1:0] SAVED_SETTING_CH1_OUT,
  output wire [SET_BITS-1:0] SAVED_SETTING_CH2_OUT,
  output wire [TAPS-1:0] WIPER_OUT_CH1_OUT,
  output wire [TAPS-1:0] WIPER_OUT_CH2_OUT
);
  localparam WORD_BITS = `DWSCU_WORD_BITS;
  localparam OP_BITS = `DWSCU_OP_BITS;
  localparam CNT_BITS = `DWSCU_CNT_BITS;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SHIFT = 2'h1;

  // Frame tracking
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg sclk_d_ff;
  reg [CNT_BITS-1:0] bit_cnt_ff;
  reg [CNT_BITS-1:0] nxt_bit_cnt;
  reg [WORD_BITS-1:0] shift_in_ff;
  reg [WORD_BITS-1:0] nxt_shift_in;
  reg [WORD_BITS-1:0] echo_ff;
  reg [WORD_BITS-1:0] nxt_echo;
  reg serial_out_ff;
  reg nxt_serial_out;
  // Setting latches and saved copies
  reg boot_ff;
  reg [SET_BITS-1:0] wiper_setting_ch1_ff;
  reg [SET_BITS-1:0] nxt_wiper_setting_ch1;
  reg [SET_BITS-1:0] wiper_setting_ch2_ff;
  reg [SET_BITS-1:0] nxt_wiper_setting_ch2;
  reg [SET_BITS-1:0] saved_setting_ch1_ff;
  reg [SET_BITS-1:0] nxt_saved_setting_ch1;
  reg [SET_BITS-1:0] saved_setting_ch2_ff;
  reg [SET_BITS-1:0] nxt_saved_setting_ch2;
  wire sclk_rise;
  wire sclk_fall;
  wire frame_start;
  wire frame_stop;
  wire frame_end;
  wire [3:0] echo_idx;
  wire [OP_BITS-1:0] op;
  wire [SET_BITS-1:0] data;

  // Serial clock edges, only while selected
  assign sclk_rise = SCLK_IN & ~sclk_d_ff & ~CS_N_IN;
  assign sclk_fall = ~SCLK_IN & sclk_d_ff & ~CS_N_IN;
  assign frame_start = (state_ff == ST_IDLE) & ~CS_N_IN;
  assign frame_stop = (state_ff == ST_SHIFT) & CS_N_IN;
  // Command taken at select release after exactly 16 clocks
  assign frame_end = frame_stop & (bit_cnt_ff == `DWSCU_CNT_FULL);
  assign echo_idx = `DWSCU_ECHO_TOP - bit_cnt_ff[3:0];
  assign op = shift_in_ff[WORD_BITS-1:WORD_BITS-OP_BITS];
  assign data = shift_in_ff[SET_BITS-1:0];

  // Outputs straight from flip-flops
  assign SERIAL_OUT_OUT = serial_out_ff;
  assign WIPER_SETTING_CH1_OUT = wiper_setting_ch1_ff;
  assign WIPER_SETTING_CH2_OUT = wiper_setting_ch2_ff;
  assign SAVED_SETTING_CH1_OUT = saved_setting_ch1_ff;
  assign SAVED_SETTING_CH2_OUT = saved_setting_ch2_ff;

  // One-hot tap select per channel
  genvar t;
  generate
    for (t = 0; t < TAPS; t = t + 1) begin : g_tap
      localparam [SET_BITS-1:0] TAP_CODE = t;
      assign WIPER_OUT_CH1_OUT[t] = (wiper_setting_ch1_ff == TAP_CODE);
      assign WIPER_OUT_CH2_OUT[t] = (wiper_setting_ch2_ff == TAP_CODE);
    end
  endgenerate

  // Select tracking
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (!CS_N_IN) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (CS_N_IN) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Rising serial clocks in this frame
  always @* begin
    nxt_bit_cnt = bit_cnt_ff;
    if (frame_start) begin
      nxt_bit_cnt = `DWSCU_CNT_ZERO;
    end
    if (sclk_rise && bit_cnt_ff != `DWSCU_CNT_MAX) begin
      nxt_bit_cnt = bit_cnt_ff + `DWSCU_CNT_ONE;
    end
  end

  // Input word, MSB first
  always @* begin
    nxt_shift_in = shift_in_ff;
    if (sclk_rise) begin
      nxt_shift_in = {shift_in_ff[WORD_BITS-2:0], SERIAL_IN_IN};
    end
  end

  // Previous word back out, MSB first
  always @* begin
    nxt_serial_out = serial_out_ff;
    if (frame_start) begin
      nxt_serial_out = echo_ff[WORD_BITS-1];
    end
    if (sclk_fall && bit_cnt_ff < `DWSCU_CNT_FULL) begin
      nxt_serial_out = echo_ff[echo_idx];
    end
  end

  // Echo word only from complete frames
  always @* begin
    nxt_echo = echo_ff;
    if (frame_end) begin
      nxt_echo = shift_in_ff;
    end
  end

  // Command decode
  always @* begin
    nxt_wiper_setting_ch1 = wiper_setting_ch1_ff;
    nxt_wiper_setting_ch2 = wiper_setting_ch2_ff;
    nxt_saved_setting_ch1 = saved_setting_ch1_ff;
    nxt_saved_setting_ch2 = saved_setting_ch2_ff;
    // Power-on restore on the first edge after reset
    if (boot_ff) begin
      nxt_wiper_setting_ch1 = saved_setting_ch1_ff;
      nxt_wiper_setting_ch2 = saved_setting_ch2_ff;
    end
    if (frame_end) begin
      case (op)
        `DWSCU_OP_LOAD_CH1: begin
          nxt_wiper_setting_ch1 = data;
        end
        `DWSCU_OP_LOAD_CH2: begin
          nxt_wiper_setting_ch2 = data;
        end
        `DWSCU_OP_INC_CH1: begin
          nxt_wiper_setting_ch1 = wiper_setting_ch1_ff + `DWSCU_SETTING_STEP;
        end
        `DWSCU_OP_SAVE_CH1: begin
          nxt_saved_setting_ch1 = wiper_setting_ch1_ff;
        end
        `DWSCU_OP_RESTORE1, `DWSCU_OP_RESTORE8: begin
          nxt_wiper_setting_ch1 = saved_setting_ch1_ff;
          nxt_wiper_setting_ch2 = saved_setting_ch2_ff;
        end
        `DWSCU_OP_NOP: begin
          // No change, echo only
          nxt_wiper_setting_ch1 = wiper_setting_ch1_ff;
        end
        default: begin
          // Unknown codes change nothing
          nxt_saved_setting_ch2 = saved_setting_ch2_ff;
        end
      endcase
    end
  end

  // Link registers
  always @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_ff <= ST_IDLE;
      sclk_d_ff <= `DWSCU_SCLK_RST;
      bit_cnt_ff <= `DWSCU_CNT_ZERO;
      shift_in_ff <= `DWSCU_ECHO_RST;
      echo_ff <= `DWSCU_ECHO_RST;
      serial_out_ff <= `DWSCU_SERIAL_OUT_RST;
    end else begin
      state_ff <= nxt_state;
      sclk_d_ff <= SCLK_IN;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_in_ff <= nxt_shift_in;
      echo_ff <= nxt_echo;
      serial_out_ff <= nxt_serial_out;
    end
  end

  // Setting registers
  always @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      boot_ff <= 1'b1;
      wiper_setting_ch1_ff <= `DWSCU_SETTING_RST;
      wiper_setting_ch2_ff <= `DWSCU_SETTING_RST;
      saved_setting_ch1_ff <= `DWSCU_SETTING_RST;
      saved_setting_ch2_ff <= `DWSCU_SETTING_RST;
    end else begin
      boot_ff <= 1'b0;
      wiper_setting_ch1_ff <= nxt_wiper_setting_ch1;
      wiper_setting_ch2_ff <= nxt_wiper_setting_ch2;
      saved_setting_ch1_ff <= nxt_saved_setting_ch1;
      saved_setting_ch2_ff <= nxt_saved_setting_ch2;
    end
  end
endmodule

// file: tb/dwscu_chk.sv
// Checker for the serial command unit
`timescale 1ns/1ps
module dwscu_chk #(parameter SET_BITS = 8, parameter TAPS = 256) (
  input wire SYS_CLK_IN, RST_N_IN, CS_N_IN, SCLK_IN, SERIAL_IN_IN, SERIAL_OUT_OUT,
  input wire [SET_BITS-1:0] WIPER_SETTING_CH1_OUT, WIPER_SETTING_CH2_OUT, SAVED_SETTING_CH1_OUT, SAVED_SETTING_CH2_OUT,
  input wire [TAPS-1:0] WIPER_OUT_CH1_OUT, WIPER_OUT_CH2_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  AST_TAP: assert property (WIPER_OUT_CH1_OUT == (256'h1 << WIPER_SETTING_CH1_OUT)) else $error("tap");
  AST_TAP2: assert property (WIPER_OUT_CH2_OUT == (256'h1 << WIPER_SETTING_CH2_OUT)) else $error("tap2");
  AST_CH2: assert property ($changed(WIPER_SETTING_CH2_OUT) |-> CS_N_IN) else $error("ch2");
  AST_ECHO: assert property (SCLK_IN [*3] |-> $stable(SERIAL_OUT_OUT)) else $error("echo");
  AST_CH1: assert property (!CS_N_IN [*3] |-> $stable(WIPER_SETTING_CH1_OUT)) else $error("ch1");
  AST_SAVE: assert property ($changed(SAVED_SETTING_CH1_OUT) |->
    SAVED_SETTING_CH1_OUT == $past(WIPER_SETTING_CH1_OUT)) else $error("save");
  AST_SV2: assert property ($stable(SAVED_SETTING_CH2_OUT)) else $error("sv2");
  AST_PON: assert property ($rose(RST_N_IN) |=> WIPER_SETTING_CH1_OUT == SAVED_SETTING_CH1_OUT) else $error("pon");
  cover property ($changed(SAVED_SETTING_CH1_OUT));
  cover property ($changed(WIPER_SETTING_CH2_OUT));
  cover property (WIPER_SETTING_CH1_OUT == 8'h00 && $past(WIPER_SETTING_CH1_OUT) == 8'hFF);
endmodule
bind dwscu_top dwscu_chk #(.SET_BITS(SET_BITS), .TAPS(TAPS)) u_dwscu_chk (.*);

// file: tb/dwscu_host.sv
// Host serial master model
`timescale 1ns/1ps
module dwscu_host (
  input wire clk_in,
  input wire so_in,
  output reg cs_n_out = 1'b1,
  output reg sck_out = 1'b0,
  output reg sdo_out = 1'b0
);
  task automatic xfer(input [15:0] w, input int n, output [15:0] e);
    e = 16'h0000;
    @(posedge clk_in) cs_n_out <= 1'b0;
    for (int i = 15; i >= 16 - n; i--) begin
      sdo_out <= w[i];
      repeat (3) @(posedge clk_in);
      e[i] = so_in;
      sck_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      sck_out <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
    cs_n_out <= 1'b1;
    sdo_out <= ~w[16 - n];
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// file: tb/tb_dual_wiper_serial_command_unit.sv
// Self-checking bench for the serial command unit
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH %0t got %0h want %0h", $time, (a), (b)); end end
module tb_dual_wiper_serial_command_unit;
  logic SYS_CLK_IN = 1'b0, RST_N_IN = 1'b0;
  wire CS_N_IN, SCLK_IN, SERIAL_IN_IN, SERIAL_OUT_OUT;
  wire [7:0] WIPER_SETTING_CH1_OUT, WIPER_SETTING_CH2_OUT, SAVED_SETTING_CH1_OUT, SAVED_SETTING_CH2_OUT;
  wire [255:0] WIPER_OUT_CH1_OUT, WIPER_OUT_CH2_OUT;
  int mismatches = 0, n_checks = 0, m1, m2, ms;
  logic [15:0] hist[$];
  logic [7:0] ops[9] = '{8'hB0, 8'hB1, 8'hE0, 8'h20, 8'h00, 8'h10, 8'h80, 8'h55, 8'hE0};
  always #50 SYS_CLK_IN = ~SYS_CLK_IN;
  dwscu_top u_dwscu_top (.*);
  dwscu_host u_dwscu_host (.clk_in(SYS_CLK_IN), .so_in(SERIAL_OUT_OUT), .cs_n_out(CS_N_IN), .sck_out(SCLK_IN),
    .sdo_out(SERIAL_IN_IN));
  task automatic cmd(input [15:0] w, input int n);
    logic [15:0] e;
    logic [15:0] want;
    want = (hist.size() > 0) ? hist[$] : 16'h0000;
    u_dwscu_host.xfer(w, n, e);
    `CHK(e >> (16 - n), want >> (16 - n))
    if (n == 16) begin
      case (w[15:8])
        8'hB0: m1 = w[7:0];
        8'hB1: m2 = w[7:0];
        8'hE0: m1 = (m1 + 1) % 256;
        8'h20: ms = m1;
        8'h10, 8'h80: begin
          m1 = ms;
          m2 = 8'h80;
        end
        default: ;
      endcase
      hist.push_back(w);
    end
    `CHK(WIPER_SETTING_CH1_OUT, m1[7:0])
    `CHK(WIPER_SETTING_CH2_OUT, m2[7:0])
    `CHK(SAVED_SETTING_CH1_OUT, ms[7:0])
    `CHK(SAVED_SETTING_CH2_OUT, 8'h80)
    `CHK(WIPER_OUT_CH1_OUT, 256'h1 << m1)
    `CHK(WIPER_OUT_CH2_OUT, 256'h1 << m2)
  endtask
  task automatic rst;
    RST_N_IN <= 1'b0;
    repeat (16) @(posedge SYS_CLK_IN);
    RST_N_IN <= 1'b1;
    repeat (3) @(posedge SYS_CLK_IN);
    m1 = 8'h80;
    m2 = 8'h80;
    ms = 8'h80;
    hist.delete();
    `CHK(WIPER_SETTING_CH1_OUT, ms[7:0])
    `CHK(WIPER_SETTING_CH2_OUT, m2[7:0])
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #3_000_000;
    mismatches++;
    complete_run;
  end
  initial begin
    void'($urandom(81));
    rst;
    for (int i = 0; i < 60; i++) cmd({ops[$urandom % 9], 8'($urandom)}, 16);
    cmd(16'hB0FF, 16);
    cmd(16'hB1FF, 8);
    cmd(16'hE012, 16);
    cmd(16'hB011, 15);
    cmd(16'h0000, 16);
    rst;
    cmd(16'h0000, 16);
    complete_run;
  end
endmodule
